// ### verilog/gpio_port_pkg.sv
// constants, field layout and carrier types for the set/clear gpio port block
// assumes a 32-bit apb master and a single 100 mhz clock domain
package gpio_port_pkg;

    // port geometry
    localparam int NUM_PORTS = 8;
    localparam int PORT_W    = 8;
    localparam int ADDR_W    = 8;
    localparam int DATA_W    = 32;

    // register byte addresses
    localparam logic [7:0] ADDR_SETCLR    = 8'h00;
    localparam logic [7:0] ADDR_ROUTE     = 8'h04;
    localparam logic [7:0] ADDR_TRIG      = 8'h08;
    localparam logic [7:0] ADDR_DIR_BASE  = 8'h20;
    localparam logic [7:0] ADDR_POL_BASE  = 8'h40;
    localparam logic [7:0] ADDR_STAT_BASE = 8'h60;

    // banked regions, selected by paddr[7:5], word index in paddr[4:2]
    localparam logic [2:0] REGION_DIR  = 3'h1;
    localparam logic [2:0] REGION_POL  = 3'h2;
    localparam logic [2:0] REGION_STAT = 3'h3;

    // field positions of the set/clear command word
    localparam int SET_LSB = 0;
    localparam int CLR_LSB = 8;
    localparam int ID_LSB  = 16;

    // field positions of a status word
    localparam int STAT_STATE_LSB = 0;
    localparam int STAT_PIN_LSB   = 8;
    localparam int STAT_DIR_LSB   = 16;

    // port identifiers
    localparam logic [7:0] PORT_ID_FIRST = 8'h01;
    localparam logic [7:0] PORT_ID_LAST  = 8'h08;
    localparam logic [7:0] PORT_ID_TRIG  = 8'h09;
    localparam int         OUT_SEL_BIT   = 7;

    // values after reset
    localparam logic [7:0] DIR_RESET   = 8'hff;
    localparam logic [7:0] POL_RESET   = 8'hff;
    localparam logic [7:0] STATE_RESET = 8'h00;
    localparam logic [7:0] ROUTE_RESET = 8'h00;

    // apb request from the master
    typedef struct packed {
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [DATA_W-1:0] pwdata;
    } apb_req_s;

    // decoded port identifier
    typedef struct packed {
        logic       valid;
        logic       trig;
        logic       writable;
        logic [2:0] idx;
    } port_sel_s;

endpackage

// ### verilog/gpio_port_set_clear.sv
// gpio port block: direction, polarity and set/clear-mask output control for
// eight 8-bit ports plus the trigger bus port, which has no polarity and is software-driven unless FIXED_DIR_PORTS is set
// assumes an apb master on the same clock and pins sampled synchronously
`timescale 1ns/10ps

module gpio_port_set_clear
    import gpio_port_pkg::*;
#(
    parameter bit FIXED_DIR_PORTS = 1'b0
) (
    // clock and reset
    input  wire logic                              clock,
    input  wire logic                              rst_n,
    // apb slave
    input  wire apb_req_s                          apb_req,
    output logic [DATA_W-1:0]                      prdata,
    output logic                                   pready,
    output logic                                   pslverr,
    // general-purpose port pins
    input  wire logic [NUM_PORTS-1:0][PORT_W-1:0]  gpio_in,
    output logic [NUM_PORTS-1:0][PORT_W-1:0]       gpio_out,
    output logic [NUM_PORTS-1:0][PORT_W-1:0]       gpio_oe,
    // trigger bus lines
    input  wire logic [PORT_W-1:0]                 trigger_bus_in,
    output logic [PORT_W-1:0]                      trigger_bus_out,
    output logic [PORT_W-1:0]                      trigger_bus_oe
);

    // decode a port identifier; fixed variant uses the top bit as out/in select
    function automatic port_sel_s decode_port(input logic [7:0] id, input logic fixed);
        port_sel_s  s;
        logic [7:0] num;
        s   = '0;
        num = fixed ? {1'b0, id[6:0]} : id;
        if (num >= PORT_ID_FIRST && num <= PORT_ID_LAST) begin
            s.valid    = 1'b1;
            s.idx      = 3'(num - PORT_ID_FIRST);
            s.writable = fixed ? id[OUT_SEL_BIT] : 1'b1;
        end else if (!fixed && id == PORT_ID_TRIG) begin
            s.valid    = 1'b1;
            s.trig     = 1'b1;
            s.writable = 1'b1;
        end
        return s;
    endfunction

    // set/clear update; set ORed last so it wins, input bits held
    function automatic logic [7:0] apply_setclr(input logic [7:0] cur,
                                                input logic [7:0] set,
                                                input logic [7:0] clr,
                                                input logic [7:0] in_mask);
        logic [7:0] upd;
        upd = (cur & ~clr) | set;
        return (cur & in_mask) | (upd & ~in_mask);
    endfunction

    // byte lane of one port inside the flattened state vector
    function automatic logic [NUM_PORTS*PORT_W-1:0] port_mask(input logic [2:0] idx);
        logic [NUM_PORTS*PORT_W-1:0] m;
        m = '0;
        m[idx*PORT_W +: PORT_W] = '1;
        return m;
    endfunction

    // storage
    logic [NUM_PORTS-1:0][PORT_W-1:0] state_reg;
    logic [NUM_PORTS-1:0][PORT_W-1:0] dir_reg;
    logic [NUM_PORTS-1:0][PORT_W-1:0] pol_reg;
    logic [NUM_PORTS-1:0][PORT_W-1:0] pin_reg;
    logic [PORT_W-1:0]                trig_state_reg;
    logic [PORT_W-1:0]                trig_pin_reg;
    logic [PORT_W-1:0]                route_reg;
    logic [DATA_W-1:0]                prdata_reg;
    logic [DATA_W-1:0]                rd_next;

    // bus phase decode
    wire logic       setup   = apb_req.psel & ~apb_req.penable;
    wire logic       access  = apb_req.psel & apb_req.penable;
    wire logic       wr      = access & apb_req.pwrite;
    wire logic [2:0] region  = apb_req.paddr[7:5];
    wire logic [2:0] ridx    = apb_req.paddr[4:2];
    wire logic       aligned = apb_req.paddr[1:0] == 2'b00;

    // register address decode
    wire logic hit_setclr = apb_req.paddr == ADDR_SETCLR;
    wire logic hit_route  = apb_req.paddr == ADDR_ROUTE;
    wire logic hit_trig   = apb_req.paddr == ADDR_TRIG;
    wire logic hit_dir    = aligned && region == REGION_DIR;
    wire logic hit_pol    = aligned && region == REGION_POL;
    wire logic hit_stat   = aligned && region == REGION_STAT;
    wire logic addr_hit   = hit_setclr | hit_route | hit_trig | hit_dir | hit_pol | hit_stat;

    // set/clear command fields
    wire logic [7:0] set_mask = apb_req.pwdata[SET_LSB +: 8];
    wire logic [7:0] clr_mask = apb_req.pwdata[CLR_LSB +: 8];
    wire logic [7:0] port_id  = apb_req.pwdata[ID_LSB +: 8];
    wire port_sel_s  sel      = decode_port(port_id, FIXED_DIR_PORTS);

    // command qualification; fixed input ports take no writes
    wire logic       setclr_wr = wr & hit_setclr;
    wire logic       wr_gp     = setclr_wr & sel.valid & ~sel.trig & sel.writable;
    wire logic       wr_trig   = setclr_wr & sel.valid & sel.trig;
    wire logic [2:0] tgt_idx   = sel.idx;

    // target port view; fixed variant output ports have no input bits
    wire logic [7:0] cur_dir   = FIXED_DIR_PORTS ? 8'h00 : dir_reg[tgt_idx];
    wire logic [7:0] tgt_state = state_reg[tgt_idx];
    wire logic [7:0] gp_update = apply_setclr(tgt_state, set_mask, clr_mask, cur_dir);
    // trigger port ignores the direction bitmap entirely
    wire logic [7:0] trig_upd  = apply_setclr(trig_state_reg, set_mask, clr_mask, 8'h00);

    // answer at once; pin update lag is never waited for
    assign pready  = 1'b1;
    assign pslverr = access & (~addr_hit | (setclr_wr & ~sel.valid));
    assign prdata  = prdata_reg;

    // output state persists between commands, whole byte at once
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_reg <= {NUM_PORTS{STATE_RESET}};
        end else if (wr_gp) begin
            state_reg[tgt_idx] <= gp_update;
        end
    end

    // trigger port accepts every write unless FIXED_DIR_PORTS is set, which leaves its id undecoded
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            trig_state_reg <= STATE_RESET;
        end else if (wr_trig) begin
            trig_state_reg <= trig_upd;
        end
    end

    // direction bitmaps, all inputs after reset
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            dir_reg <= {NUM_PORTS{DIR_RESET}};
        end else if (wr && hit_dir) begin
            dir_reg[ridx] <= apb_req.pwdata[7:0];
        end
    end

    // polarity flags, active low after reset
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            pol_reg <= {NUM_PORTS{POL_RESET}};
        end else if (wr && hit_pol) begin
            pol_reg[ridx] <= apb_req.pwdata[7:0];
        end
    end

    // trigger line routing, nothing routed after reset
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            route_reg <= ROUTE_RESET;
        end else if (wr && hit_route) begin
            route_reg <= apb_req.pwdata[7:0];
        end
    end

    // pin stage: one cycle behind the logical state, well inside the allowed lag
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            pin_reg      <= {NUM_PORTS{STATE_RESET ^ POL_RESET}};
            trig_pin_reg <= STATE_RESET;
        end else begin
            pin_reg      <= state_reg ^ pol_reg;
            trig_pin_reg <= trig_state_reg;
        end
    end

    // read mux; unmapped addresses read zero
    always_comb begin
        rd_next = '0;
        if (hit_route) begin
            rd_next[7:0] = route_reg;
        end else if (hit_trig) begin
            rd_next[STAT_STATE_LSB +: 8] = trig_state_reg;
            rd_next[STAT_PIN_LSB +: 8]   = trigger_bus_in;
            rd_next[STAT_DIR_LSB +: 8]   = ~route_reg;
        end else if (hit_dir) begin
            rd_next[7:0] = dir_reg[ridx];
        end else if (hit_pol) begin
            rd_next[7:0] = pol_reg[ridx];
        end else if (hit_stat) begin
            rd_next[STAT_STATE_LSB +: 8] = state_reg[ridx];
            rd_next[STAT_PIN_LSB +: 8]   = gpio_in[ridx];
            rd_next[STAT_DIR_LSB +: 8]   = dir_reg[ridx];
        end
    end

    // read data caught in the setup cycle so it stands through the access
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            prdata_reg <= '0;
        end else if (setup && !apb_req.pwrite) begin
            prdata_reg <= rd_next;
        end
    end

    // pins: fixed variant has dedicated output lines
    assign gpio_out        = pin_reg;
    assign gpio_oe         = FIXED_DIR_PORTS ? '1 : ~dir_reg;
    assign trigger_bus_out = trig_pin_reg;
    assign trigger_bus_oe  = route_reg;

    // helper terms for the checks below
    wire logic [7:0] both_on  = set_mask & clr_mask & ~cur_dir;
    wire logic [7:0] hold_msk = ~(set_mask | clr_mask) | cur_dir;
    wire logic [7:0] on_msk   = set_mask & ~cur_dir;
    wire logic [7:0] off_msk  = clr_mask & ~set_mask & ~cur_dir;
    // every lane except the one being written
    wire logic [NUM_PORTS*PORT_W-1:0] keep_mask = ~port_mask(tgt_idx);

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    a_reset_values: assert property (disable iff (1'b0)
        !rst_n |=> (dir_reg == {NUM_PORTS{DIR_RESET}} && route_reg == ROUTE_RESET
                    && pol_reg == {NUM_PORTS{POL_RESET}}))
        else $error("reset values of direction, routing or polarity wrong");

    a_set_turns_on: assert property (
        wr_gp |=> (state_reg[$past(tgt_idx)] & $past(on_msk)) == $past(on_msk))
        else $error("set mask bit did not turn on");

    a_clear_turns_off: assert property (
        wr_gp |=> (state_reg[$past(tgt_idx)] & $past(off_msk)) == 8'h00)
        else $error("clear mask bit did not turn off");

    a_set_wins: assert property (
        (wr_gp && both_on != 8'h00) |=>
            (state_reg[$past(tgt_idx)] & $past(both_on)) == $past(both_on))
        else $error("bit in both masks was not set");

    a_input_held: assert property (
        wr_gp |=> (state_reg[$past(tgt_idx)] & $past(hold_msk))
                  == ($past(tgt_state) & $past(hold_msk)))
        else $error("held or input bit changed on a write");

    a_no_wait: assert property (
        access |-> pready)
        else $error("command interface stalled");

    a_pin_follows: assert property (
        wr_gp |=> ##1 gpio_out[$past(tgt_idx, 2)]
                  == ($past(gp_update, 2) ^ pol_reg[$past(tgt_idx, 2)]))
        else $error("pin level does not follow state and polarity");

    // no trigger line may be driven straight out of reset
    a_trig_unrouted: assert property (disable iff (1'b0)
        !rst_n |=> (trigger_bus_oe == 8'h00 && trigger_bus_out == 8'h00))
        else $error("trigger line driven without routing");

    a_trig_ignores_dir: assert property (
        wr_trig |=> (trig_state_reg & $past(set_mask)) == $past(set_mask))
        else $error("trigger port set bit lost");

    a_bad_port_error: assert property (
        (setclr_wr && !sel.valid) |-> (pslverr && $stable(state_reg) ##1 $stable(state_reg)))
        else $error("invalid port id not refused");

    a_fixed_input_port: assert property (
        (setclr_wr && FIXED_DIR_PORTS && !port_id[OUT_SEL_BIT]) |=> $stable(state_reg))
        else $error("write to fixed input port changed state");

    a_port_atomic: assert property (
        $changed(state_reg) |-> $past(wr_gp))
        else $error("state changed without a port write");

    c_set_and_clear: cover property (wr_gp && both_on != 8'h00);
    c_input_ignored: cover property (wr_gp && (cur_dir & (set_mask | clr_mask)) != 8'h00);
    c_trig_routed:   cover property (wr_trig && route_reg != 8'h00);
    c_unmapped:      cover property (access && !addr_hit);
    c_pol_written:   cover property (wr && hit_pol);

    // further checks on storage and isolation between ports;
    // these catch stray enables that the mask checks above cannot see,
    // since those only look at the lane being written

    // state only moves on an accepted port write
    a_state_held: assert property (
        !wr_gp |=> $stable(state_reg))
        else $error("port state changed with no write");

    // a write to one port leaves the other seven alone
    a_other_ports: assert property (
        wr_gp |=> ((state_reg ^ $past(state_reg)) & $past(keep_mask)) == '0)
        else $error("write disturbed another port");

    // general ports never see a trigger port write
    a_trig_apart: assert property (
        wr_trig |=> $stable(state_reg))
        else $error("trigger write changed a general port");

    // trigger port state never sees a general port write
    a_gp_apart: assert property (
        wr_gp |=> $stable(trig_state_reg))
        else $error("general write changed trigger port");

    // clear on the trigger port; set excluded since set wins
    a_trig_clear: assert property (
        wr_trig |=> (trig_state_reg & $past(clr_mask & ~set_mask)) == 8'h00)
        else $error("trigger port clear bit kept");

    // trigger pins trail the software state by one stage
    a_trig_pin: assert property (
        wr_trig |=> ##1 (trigger_bus_out & $past(set_mask, 2)) == $past(set_mask, 2))
        else $error("trigger pin does not follow set bit");

    // direction word lands whole in the addressed port
    a_dir_write: assert property (
        (wr && hit_dir) |=> dir_reg[$past(ridx)] == $past(apb_req.pwdata[7:0]))
        else $error("direction write lost");

    // polarity word lands whole in the addressed port
    a_pol_write: assert property (
        (wr && hit_pol) |=> pol_reg[$past(ridx)] == $past(apb_req.pwdata[7:0]))
        else $error("polarity write lost");

    // routing word lands whole
    a_route_write: assert property (
        (wr && hit_route) |=> route_reg == $past(apb_req.pwdata[7:0]))
        else $error("routing write lost");

    // refused addresses leave direction, polarity, routing and general port state as they were
    a_unmapped_inert: assert property (
        (access && !addr_hit) |=> ($stable(dir_reg) && $stable(pol_reg)
                                   && $stable(route_reg) && $stable(state_reg)))
        else $error("unmapped access changed a register");

    // error flag only in the access cycle, never outside a transfer
    a_err_in_access: assert property (
        pslverr |-> access)
        else $error("error flag outside access");

endmodule // gpio_port_set_clear

// ### test/pin_model.sv
// pin model for the gpio block: loops driven pins back, inverts released lines
// assumes direct wiring to the block's pin and trigger bus ports
`timescale 1ns/10ps
module pin_model
    import gpio_port_pkg::*;
(
    // block side
    input  wire logic [NUM_PORTS-1:0][PORT_W-1:0] gpio_out,
    input  wire logic [NUM_PORTS-1:0][PORT_W-1:0] gpio_oe,
    input  wire logic [PORT_W-1:0]                trigger_bus_out,
    input  wire logic [PORT_W-1:0]                trigger_bus_oe,
    // sensed levels
    output logic      [NUM_PORTS-1:0][PORT_W-1:0] gpio_in,
    output logic      [PORT_W-1:0]                trigger_bus_in
);
    // released lines read inverted, so a stale level never passes as driven
    assign gpio_in        = ~(gpio_out ^ gpio_oe);
    assign trigger_bus_in = ~(trigger_bus_out ^ trigger_bus_oe);
endmodule // pin_model

// ### test/tb_top.sv
// self-checking bench for the set/clear gpio port block
// assumes the package, the block and pin_model are compiled first
`timescale 1ns/10ps
module tb_top
    import gpio_port_pkg::*;
;
    // clock, reset and bus
    logic                              clock;
    logic                              rst_n;
    apb_req_s                          apb_req;
    logic [DATA_W-1:0]                 prdata;
    logic                              pready;
    logic                              pslverr;
    // pins
    logic [NUM_PORTS-1:0][PORT_W-1:0]  gpio_in;
    logic [NUM_PORTS-1:0][PORT_W-1:0]  gpio_out;
    logic [NUM_PORTS-1:0][PORT_W-1:0]  gpio_oe;
    logic [PORT_W-1:0]                 trigger_bus_in;
    logic [PORT_W-1:0]                 trigger_bus_out;
    logic [PORT_W-1:0]                 trigger_bus_oe;
    // fixed-direction variant on the same bus
    logic [NUM_PORTS-1:0][PORT_W-1:0]  fx_out;
    logic [NUM_PORTS-1:0][PORT_W-1:0]  fx_oe;
    // bookkeeping
    logic [31:0]                       rdv;
    logic                              errv;
    int                                n_fail;
    int                                checks_done;

    gpio_port_set_clear i_dut (.clock(clock), .rst_n(rst_n), .apb_req(apb_req),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .gpio_in(gpio_in),
        .gpio_out(gpio_out), .gpio_oe(gpio_oe), .trigger_bus_in(trigger_bus_in),
        .trigger_bus_out(trigger_bus_out), .trigger_bus_oe(trigger_bus_oe));

    gpio_port_set_clear #(.FIXED_DIR_PORTS(1'b1)) i_dut_fixed (.clock(clock), .rst_n(rst_n),
        .apb_req(apb_req), .prdata(), .pready(), .pslverr(), .gpio_in(gpio_in),
        .gpio_out(fx_out), .gpio_oe(fx_oe), .trigger_bus_in(trigger_bus_in),
        .trigger_bus_out(), .trigger_bus_oe());

    pin_model i_pins (.gpio_out(gpio_out), .gpio_oe(gpio_oe), .gpio_in(gpio_in),
        .trigger_bus_out(trigger_bus_out), .trigger_bus_oe(trigger_bus_oe),
        .trigger_bus_in(trigger_bus_in));

    // 100 mhz clock
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up();
        if (n_fail == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // one apb transfer; a dead slave is caught by the watchdog
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
        @(posedge clock);
        apb_req.psel    <= 1'b1;
        apb_req.pwrite  <= wr;
        apb_req.paddr   <= addr;
        apb_req.pwdata  <= wd;
        @(posedge clock);
        apb_req.penable <= 1'b1;
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        rdv = prdata;
        errv = pslverr;
        apb_req.psel    <= 1'b0;
        apb_req.penable <= 1'b0;
    endtask

    task automatic sc(input logic [7:0] id, input logic [7:0] set, input logic [7:0] clr);
        apb(1'b1, ADDR_SETCLR, {8'h00, id, clr, set});
    endtask

    // pins trail the state by one registered stage
    task automatic pins();
        repeat (2) @(posedge clock);
        #1;
    endtask

    task automatic t_reset();
        check(gpio_oe[3:0], 32'h0);
        check(gpio_out[7:4], 32'hffffffff);
        check({trigger_bus_oe, trigger_bus_out}, 32'h0);
        apb(1'b0, ADDR_DIR_BASE + 8'h1c, 32'h0);
        check(rdv, 32'hff);
        apb(1'b0, ADDR_POL_BASE, 32'h0);
        check(rdv, 32'hff);
        apb(1'b0, ADDR_ROUTE, 32'h0);
        check(rdv, 32'h0);
    endtask

    // port 2 low nibble output; masks hit outputs, inputs and overlaps
    task automatic t_setclr();
        apb(1'b1, ADDR_DIR_BASE + 8'h04, 32'hf0);
        sc(8'h02, 8'h3b, 8'h06);
        check(errv, 1'b0);
        pins();
        check(gpio_oe[1], 8'h0f);
        check(gpio_out[1], 8'hf4);
        sc(8'h02, 8'h00, 8'h08);
        sc(8'h03, 8'hff, 8'h00);
        pins();
        check(gpio_out[1], 8'hfc);
        check(gpio_out[2], 8'hff);
        apb(1'b0, ADDR_STAT_BASE + 8'h04, 32'h0);
        check(rdv, 32'h00f00c03);
        apb(1'b1, ADDR_POL_BASE + 8'h04, 32'h0);
        pins();
        check(gpio_out[1], 8'h03);
    endtask

    task automatic t_trig();
        sc(PORT_ID_TRIG, 8'h05, 8'h00);
        pins();
        check({trigger_bus_oe, trigger_bus_out}, 32'h0005);
        apb(1'b1, ADDR_ROUTE, 32'h01);
        pins();
        check(trigger_bus_oe, 8'h01);
        apb(1'b0, ADDR_TRIG, 32'h0);
        check(rdv, 32'h00fefb05);
    endtask

    // fixed variant: top id bit picks the output port, plain ids ignored
    task automatic t_fixed();
        check(fx_oe[3:0], 32'hffffffff);
        sc(8'h82, 8'h81, 8'h00);
        check(errv, 1'b1);
        sc(8'h02, 8'h00, 8'h80);
        pins();
        check(fx_out[1], 8'h81);
        check(gpio_out[1], 8'h03);
    endtask

    // every legal id holds, outside ids and addresses are refused
    task automatic t_refuse();
        for (int i = 1; i <= 9; i++) begin
            sc(i[7:0], 8'h00, 8'h00);
            check(errv, 1'b0);
        end
        sc(8'h00, 8'hff, 8'h00);
        check(errv, 1'b1);
        sc(8'h0a, 8'hff, 8'h00);
        check(errv, 1'b1);
        pins();
        check(gpio_out[1], 8'h03);
        apb(1'b0, 8'h80, 32'h0);
        check(errv, 1'b1);
        check(rdv, 32'h0);
    endtask

    // main sequence
    initial begin
        n_fail = 0;
        checks_done = 0;
        rst_n = 1'b0;
        apb_req = '0;
        repeat (16) @(posedge clock);
        rst_n <= 1'b1;
        #1;
        t_reset();
        t_setclr();
        t_trig();
        t_fixed();
        t_refuse();
        wrap_up();
    end

    // watchdog, far beyond the hundred or so cycles the tests need
    initial begin
        #200us;
        n_fail++;
        wrap_up();
    end
endmodule // tb_top
